// >>> msc_pkg.sv
package msc_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS       = 10;
   // Latest start of connect/disconnect procedures after a request, in ms
   localparam int unsigned PROC_START_MS       = 1000;
   localparam int unsigned PROC_START_CYCLES   = (PROC_START_MS * 1000000) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W               = 27;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic        SYNC_RESET_LEVEL    = 1'h1;
   localparam logic        LAMP_RESET_LEVEL    = 1'h1;
   localparam logic        OUT_RESET_LEVEL     = 1'h0;
   // Open-drain pins only ever pull low
   localparam logic        WAKE_DRIVE_LEVEL    = 1'h0;
   localparam logic [CNT_W-1:0] CNT_ZERO       = 27'h0;

   typedef enum logic [2:0] {
      MSC_RADIO_OFF,
      MSC_CONNECT_WAIT,
      MSC_RADIO_ON,
      MSC_DISCONNECT_WAIT
   } msc_radio_state_t;

endpackage

// >>> msc_system_control.sv
`timescale 1ns/1ps
module msc_system_control (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic sys_rst,
   // Host pins (pull-ups assumed on the pad: open reads high)
   input  wire logic radio_kill_n,
   input  wire logic tx_power_cut_n,
   output logic      status_lamp_n,
   output logic      host_wake_n_o,
   output logic      host_wake_n_oe,
   // Modem core side
   input  wire logic sw_radio_off,
   input  wire logic powered,
   input  wire logic registered,
   input  wire logic link_active,
   input  wire logic in_sel_suspend,
   input  wire logic wake_request,
   input  wire logic disconnect_done,
   output logic      start_disconnect,
   output logic      start_connect,
   output logic      rf_enable,
   output logic      tx_power_reduce,
   output logic      suspend_exit,
   output logic      kill_active
);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   // Reset to the pulled-up level so a floating pin never reads as an assertion
   logic kill_meta_reg;
   logic kill_sync_reg;
   logic kill_prev_reg;
   logic cut_meta_reg;
   logic cut_sync_reg;

   // Both pins are active low; one decode keeps their polarity handling alike
   function automatic logic msc_pin_asserted(input logic level_n);
      return ~level_n;
   endfunction

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         kill_meta_reg <= msc_pkg::SYNC_RESET_LEVEL;
         kill_sync_reg <= msc_pkg::SYNC_RESET_LEVEL;
      end else begin
         kill_meta_reg <= radio_kill_n;
         kill_sync_reg <= kill_meta_reg;
      end
   end

   // Previous synchronised level, for the release edge
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         kill_prev_reg <= msc_pkg::SYNC_RESET_LEVEL;
      end else begin
         kill_prev_reg <= kill_sync_reg;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cut_meta_reg <= msc_pkg::SYNC_RESET_LEVEL;
         cut_sync_reg <= msc_pkg::SYNC_RESET_LEVEL;
      end else begin
         cut_meta_reg <= tx_power_cut_n;
         cut_sync_reg <= cut_meta_reg;
      end
   end

   // No debounce here: the host cleans the switch
   logic hw_kill;
   logic radio_off_req;
   logic kill_release;
   logic cut_req;
   assign hw_kill       = msc_pin_asserted(kill_sync_reg);
   assign cut_req       = msc_pin_asserted(cut_sync_reg);
   assign radio_off_req = hw_kill | sw_radio_off;
   // A rising synchronised level is the kill release
   assign kill_release  = kill_sync_reg & ~kill_prev_reg;

   // ------------------------------------------------------------
   // Radio state machine
   // ------------------------------------------------------------
   // Procedures are kicked on the first cycle of a request seen in the off or on state; a request met in a wait state is held until that state ends
   msc_pkg::msc_radio_state_t state_reg;
   msc_pkg::msc_radio_state_t state_next;

   // RF is live while on and while disconnect procedures still run
   function automatic logic msc_rf_live(input msc_pkg::msc_radio_state_t st);
      return (st == msc_pkg::MSC_RADIO_ON) || (st == msc_pkg::MSC_DISCONNECT_WAIT);
   endfunction

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         msc_pkg::MSC_RADIO_OFF: begin
            if (!radio_off_req) begin
               state_next = msc_pkg::MSC_CONNECT_WAIT;
            end
         end
         msc_pkg::MSC_CONNECT_WAIT: begin
            // An off request arriving here is served from the on state
            state_next = msc_pkg::MSC_RADIO_ON;
         end
         msc_pkg::MSC_RADIO_ON: begin
            if (radio_off_req) begin
               state_next = msc_pkg::MSC_DISCONNECT_WAIT;
            end
         end
         msc_pkg::MSC_DISCONNECT_WAIT: begin
            if (disconnect_done) begin
               state_next = msc_pkg::MSC_RADIO_OFF;
            end
         end
         default: begin
            state_next = msc_pkg::MSC_RADIO_OFF;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= msc_pkg::MSC_RADIO_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------
   // Procedure strobes and RF gate
   // ------------------------------------------------------------
   // Each strobe lasts one cycle because the state has moved on by the next edge
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         start_disconnect <= msc_pkg::OUT_RESET_LEVEL;
      end else begin
         start_disconnect <= (state_reg == msc_pkg::MSC_RADIO_ON) && radio_off_req;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         start_connect <= msc_pkg::OUT_RESET_LEVEL;
      end else begin
         start_connect <= (state_reg == msc_pkg::MSC_RADIO_OFF) && !radio_off_req;
      end
   end

   // RF stays on through disconnect so the network procedures can finish
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rf_enable <= msc_pkg::OUT_RESET_LEVEL;
      end else begin
         rf_enable <= msc_rf_live(state_next);
      end
   end

   // ------------------------------------------------------------
   // Power reduction, suspend exit, status
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_power_reduce <= msc_pkg::OUT_RESET_LEVEL;
      end else begin
         tx_power_reduce <= cut_req;
      end
   end

   // Any release while suspended wakes the core; a spurious exit costs only power
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         suspend_exit <= msc_pkg::OUT_RESET_LEVEL;
      end else begin
         suspend_exit <= kill_release & in_sel_suspend;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         kill_active <= msc_pkg::OUT_RESET_LEVEL;
      end else begin
         kill_active <= hw_kill;
      end
   end

   // ------------------------------------------------------------
   // Lamp and wake pins
   // ------------------------------------------------------------
   // Lit only in the quiet registered state; traffic or no service leaves it dark
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         status_lamp_n <= msc_pkg::LAMP_RESET_LEVEL;
      end else begin
         status_lamp_n <= ~(powered & registered & ~link_active);
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         host_wake_n_oe <= msc_pkg::OUT_RESET_LEVEL;
      end else begin
         host_wake_n_oe <= wake_request;
      end
   end

   // Open drain: only ever drive low, the host pull-up makes the high level
   assign host_wake_n_o = msc_pkg::WAKE_DRIVE_LEVEL;

endmodule // msc_system_control

// >>> msc_chk.sv
`timescale 1ns/1ps
module msc_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Host pins
   input wire logic radio_kill_n,
   input wire logic tx_power_cut_n,
   input wire logic status_lamp_n,
   input wire logic host_wake_n_oe,
   // Modem core status
   input wire logic powered,
   input wire logic registered,
   input wire logic link_active,
   input wire logic in_sel_suspend,
   input wire logic wake_request,
   input wire logic disconnect_done,
   // Modem core control
   input wire logic start_disconnect,
   input wire logic start_connect,
   input wire logic rf_enable,
   input wire logic tx_power_reduce,
   input wire logic suspend_exit,
   input wire logic kill_active
);
   // Edges since reset release: $past must not look back into reset
   logic [1:0] age;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) age <= 2'h0;
      else if (age != 2'h3) age <= age + 2'h1;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_kill_sync_lag: assert property (age == 2'h3 |-> kill_active == !$past(radio_kill_n, 3))
      else $error("kill_active lag wrong");
   a_cut_sync_lag: assert property (age == 2'h3 |-> tx_power_reduce == !$past(tx_power_cut_n, 3))
      else $error("tx_power_reduce lag wrong");
   a_lamp_idle_lit: assert property (age != 2'h0 |-> status_lamp_n == !$past(powered && registered && !link_active))
      else $error("status lamp wrong");
   a_wake_drive_low: assert property (age != 2'h0 |-> host_wake_n_oe == $past(wake_request))
      else $error("wake drive wrong");
   a_kill_no_connect: assert property (kill_active |-> !start_connect)
      else $error("connect while killed");
   a_connect_then_on: assert property (start_connect |=> rf_enable && !start_connect)
      else $error("connect did not enable rf");
   a_done_rf_off: assert property (start_disconnect ##[1:12] $rose(disconnect_done) |=> !rf_enable)
      else $error("rf still on after disconnect");
   a_suspend_exit_edge: assert property (age != 2'h0 |-> suspend_exit == ($fell(kill_active) && $past(in_sel_suspend)))
      else $error("suspend exit wrong");
endmodule // msc_chk
bind msc_system_control msc_chk msc_chk_inst (
   .mclk             (mclk),
   .sys_rst          (sys_rst),
   .radio_kill_n     (radio_kill_n),
   .tx_power_cut_n   (tx_power_cut_n),
   .status_lamp_n    (status_lamp_n),
   .host_wake_n_oe   (host_wake_n_oe),
   .powered          (powered),
   .registered       (registered),
   .link_active      (link_active),
   .in_sel_suspend   (in_sel_suspend),
   .wake_request     (wake_request),
   .disconnect_done  (disconnect_done),
   .start_disconnect (start_disconnect),
   .start_connect    (start_connect),
   .rf_enable        (rf_enable),
   .tx_power_reduce  (tx_power_reduce),
   .suspend_exit     (suspend_exit),
   .kill_active      (kill_active)
);

// >>> msc_host.sv
`timescale 1ns/1ps
module msc_host (
   // Clock
   input  wire logic       mclk,
   // Design outputs seen by the host
   input  wire logic       start_disconnect,
   input  wire logic       host_wake_n_o,
   input  wire logic       host_wake_n_oe,
   // Scenario control
   input  wire logic [3:0] done_dly,
   // Answer back to the design, and the wake line level the host sees
   output logic            disconnect_done = 1'b0,
   output logic            wake_line
);
   logic [3:0] cnt = 4'h0;
   // Open drain: the host pull-up wins whenever nobody sinks the line
   assign wake_line = host_wake_n_oe ? host_wake_n_o : 1'b1;
   // Network detach finishes a variable number of cycles after it starts
   always @(posedge mclk) begin
      disconnect_done <= (cnt == 4'h1);
      cnt <= start_disconnect ? done_dly : cnt - (cnt != 4'h0);
   end
endmodule // msc_host

// >>> msc_system_control_tb.sv
`timescale 1ns/1ps
module msc_system_control_tb;
   logic mclk = 1'b0, sys_rst = 1'b1, radio_kill_n = 1'b1, tx_power_cut_n = 1'b1, sw_radio_off = 1'b0;
   logic powered = 1'b0, registered = 1'b0, link_active = 1'b0, in_sel_suspend = 1'b0, wake_request = 1'b0;
   logic status_lamp_n, host_wake_n_o, host_wake_n_oe, disconnect_done, start_disconnect, start_connect;
   logic rf_enable, tx_power_reduce, suspend_exit, kill_active, wake_line;
   logic [3:0] done_dly = 4'h1;
   logic [2:0] exp_q[$];
   int fails = 0, num_checks = 0, seed = 31;
   always #5 mclk = ~mclk;
   msc_system_control msc_system_control_inst (
      .mclk             (mclk),
      .sys_rst          (sys_rst),
      .radio_kill_n     (radio_kill_n),
      .tx_power_cut_n   (tx_power_cut_n),
      .status_lamp_n    (status_lamp_n),
      .host_wake_n_o    (host_wake_n_o),
      .host_wake_n_oe   (host_wake_n_oe),
      .sw_radio_off     (sw_radio_off),
      .powered          (powered),
      .registered       (registered),
      .link_active      (link_active),
      .in_sel_suspend   (in_sel_suspend),
      .wake_request     (wake_request),
      .disconnect_done  (disconnect_done),
      .start_disconnect (start_disconnect),
      .start_connect    (start_connect),
      .rf_enable        (rf_enable),
      .tx_power_reduce  (tx_power_reduce),
      .suspend_exit     (suspend_exit),
      .kill_active      (kill_active)
   );
   msc_host msc_host_inst (
      .mclk             (mclk),
      .start_disconnect (start_disconnect),
      .host_wake_n_o    (host_wake_n_o),
      .host_wake_n_oe   (host_wake_n_oe),
      .done_dly         (done_dly),
      .disconnect_done  (disconnect_done),
      .wake_line        (wake_line)
   );
   // Procedure and suspend strobes
   task chk_pulse(input logic [2:0] got, input logic [2:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Level outputs and pin levels
   task chk_level(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task test_done;
      if (exp_q.size() != 0) fails++;
      if (fails == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task wt(input logic v);
      for (int i = 0; i < 60 && rf_enable !== v; i++) @(posedge mclk);
      if (rf_enable !== v) begin
         fails++;
         test_done;
      end
   endtask
   // Pulses are noted as {suspend_exit, start_disconnect, start_connect}
   always @(posedge mclk) if (!sys_rst && (start_connect | start_disconnect | suspend_exit) === 1'b1) begin
      chk_pulse({suspend_exit, start_disconnect, start_connect}, exp_q.size() ? exp_q.pop_front() : 3'h0);
   end
   initial begin
      exp_q.push_back(3'h1);
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      wt(1'b1);
      for (int k = 0; k < 2; k++) begin
         exp_q.push_back(3'h2);
         sw_radio_off <= 1'b1;
         wt(1'b0);
         exp_q.push_back(3'h1);
         sw_radio_off <= 1'b0;
         wt(1'b1);
         done_dly <= 4'h9;
      end
      // Kill only as a last resort, with a clean bounce-free level
      in_sel_suspend <= 1'b1;
      exp_q.push_back(3'h2);
      radio_kill_n <= 1'b0;
      wt(1'b0);
      chk_level(kill_active, 1'b1);
      exp_q.push_back(3'h5);
      radio_kill_n <= 1'b1;
      wt(1'b1);
      for (int k = 0; k < 4; k++) begin
         tx_power_cut_n <= k[0];
         repeat (4) @(posedge mclk);
         chk_level(tx_power_reduce, !k[0]);
      end
      for (int k = 0; k < 24; k++) begin
         {powered, registered, link_active, wake_request} <= 4'($random(seed));
         repeat (2) @(posedge mclk);
         chk_level(status_lamp_n, !(powered && registered && !link_active));
         chk_level(wake_line, !wake_request);
      end
      // Mid-run reset: dark lamp, released wake line, RF off, then a fresh connect
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      chk_level(status_lamp_n, 1'b1);
      chk_level(wake_line, 1'b1);
      chk_level(rf_enable, 1'b0);
      exp_q.push_back(3'h1);
      sys_rst <= 1'b0;
      wt(1'b1);
      test_done;
   end
endmodule // msc_system_control_tb
